/* File: design/isacr_top.sv */
// two-wire bus status, clock control, data and own-address registers with the byte engine
`timescale 1ns/10ps

module isacr_top (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// two-wire bus pins, open drain
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_n,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n,
	// event request
	output logic            irq
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [7:0]          ctrl_r;
	logic [7:0]          ccr_r;
	logic [7:0]          oal_r;
	logic [7:0]          oah_r;
	logic [7:0]          dr_r;
	logic                scl_s1, scl_s2, scl_s3;
	logic                sda_s1, sda_s2, sda_s3;
	isacr_pkg::isacr_state_t state_r;
	logic [1:0]          ph_r;
	logic [3:0]          bit_r;
	logic [7:0]          shift_r;
	logic [8:0]          hcnt_r;
	logic [8:0]          half;
	logic                scl_low_r, sda_low_r;
	logic                tx_r, addr_ph_r, dir_r, ten_pend_r, ack_seen_r, slv_acked_r;
	logic                sb_r, ten_bit_header_flag_r, btf_r, address_matched_flag_r, master_r, busy_r;
	logic                af_r, stop_seen_flag_r, arb_lost_flag_r, bus_error_flag_r, general_call_flag_r;
	logic                sr1_seen_r, sr2_seen_r, clr_start_r, clr_stop_r;
	logic                pe, ack_en, tick, summary_event_flag;
	logic                scl_rise, scl_fall, start_det, stop_det, mid_byte;
	logic                rd_sr1, rd_sr2, rd_dr, wr_dr, dis_wr;
	logic                gc_hit, a7_hit, hdr_hit, a10_hit, addr_hit;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; the first stage feeds only the second

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	// bus edges and conditions seen on the synchronised lines
	assign scl_rise  = scl_s2 & ~scl_s3;
	assign scl_fall  = ~scl_s2 & scl_s3;
	assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	assign mid_byte  = (bit_r != 4'h0) && (bit_r != isacr_pkg::BIT_PRE);

	// software access strobes
	assign rd_sr1 = reg_rd && (reg_addr == isacr_pkg::OFS_STATUS_ONE);
	assign rd_sr2 = reg_rd && (reg_addr == isacr_pkg::OFS_ERROR_STAT);
	assign rd_dr  = reg_rd && (reg_addr == isacr_pkg::OFS_DATA);
	assign wr_dr  = reg_wr && (reg_addr == isacr_pkg::OFS_DATA);
	// a control write with the enable bit low
	assign dis_wr = reg_wr && (reg_addr == isacr_pkg::OFS_CTRL)
		&& !reg_wdata[isacr_pkg::CTRL_PERIPH_EN];

	assign pe     = ctrl_r[isacr_pkg::CTRL_PERIPH_EN];
	assign ack_en = ctrl_r[isacr_pkg::CTRL_ACK_EN];

	// address matching on the byte just shifted in
	assign gc_hit  = ctrl_r[isacr_pkg::CTRL_GC_EN]
		&& (shift_r == isacr_pkg::ADDR_GENERAL_CALL);
	assign a7_hit  = !ten_pend_r && (shift_r[7:1] == oal_r[7:1])
		&& (shift_r != isacr_pkg::ADDR_NEVER_ANSWER);
	assign hdr_hit = !ten_pend_r && (shift_r[7:3] == isacr_pkg::TEN_BIT_HEADER)
		&& (shift_r[2:1] == oah_r[2:1]);
	assign a10_hit = ten_pend_r && (shift_r == oal_r);
	assign addr_hit = gc_hit | a7_hit | hdr_hit | a10_hit;

	// scl half period from divider and speed mode
	always_comb begin
		if (ccr_r[isacr_pkg::CCR_SPEED_MODE]) begin
			half = {2'b00, ccr_r[6:0]} + isacr_pkg::SCL_HALF_BASE_FAST;
		end else begin
			half = {1'b0, ccr_r[6:0], 1'b0} + isacr_pkg::SCL_HALF_BASE_STD;
		end
	end

	assign tick = (hcnt_r == 9'h000);
	assign summary_event_flag  = ten_bit_header_flag_r | btf_r | address_matched_flag_r | sb_r | af_r | stop_seen_flag_r | arb_lost_flag_r | bus_error_flag_r;
	assign irq  = ctrl_r[isacr_pkg::CTRL_IRQ_EN] & summary_event_flag;

	// open drain: the level driven is always low, only the enables move
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_n = ~scl_low_r;
	assign sda_oe_n = ~sda_low_r;

	////////////////////////////////////////////////////////////////////////////////
	// control register; the first write with enable set only sets enable

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= isacr_pkg::RST_CTRL;
		end else if (reg_wr && (reg_addr == isacr_pkg::OFS_CTRL)) begin
			if (!reg_wdata[isacr_pkg::CTRL_PERIPH_EN]) begin
				ctrl_r <= {6'h00, reg_wdata[isacr_pkg::CTRL_STOP], 1'b0}; // stop bit taken from the written data, all other bits cleared
			end else if (!pe) begin
				ctrl_r <= ctrl_r | 8'h20;
			end else begin
				ctrl_r <= {2'b00, reg_wdata[5:0]};
			end
		end else begin
			if (clr_start_r) begin
				ctrl_r[isacr_pkg::CTRL_START] <= 1'b0;
			end
			if (clr_stop_r) begin
				ctrl_r[isacr_pkg::CTRL_STOP] <= 1'b0;
			end
		end
	end

	// clock control and own address: none of them is touched by disable
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ccr_r <= isacr_pkg::RST_CLOCK_CTRL;
			oal_r <= isacr_pkg::RST_OWN_LOW;
			oah_r <= isacr_pkg::RST_OWN_HIGH;
		end else if (reg_wr) begin
			if (reg_addr == isacr_pkg::OFS_CLOCK_CTRL) begin
				ccr_r <= reg_wdata;
			end else if (reg_addr == isacr_pkg::OFS_OWN_LOW) begin
				oal_r <= reg_wdata;
			end else if (reg_addr == isacr_pkg::OFS_OWN_HIGH) begin
				oah_r[2:1] <= reg_wdata[2:1];
				if (!pe) begin
					oah_r[7:6] <= reg_wdata[7:6];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data, registered, one cycle after the read strobe; unmapped reads give zero

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == isacr_pkg::OFS_CTRL) begin
				reg_rdata <= ctrl_r;
			end else if (reg_addr == isacr_pkg::OFS_STATUS_ONE) begin
				reg_rdata <= {summary_event_flag, ten_bit_header_flag_r, btf_r & tx_r, busy_r, btf_r, address_matched_flag_r, master_r, sb_r};
			end else if (reg_addr == isacr_pkg::OFS_ERROR_STAT) begin
				reg_rdata <= {3'b000, af_r, stop_seen_flag_r, arb_lost_flag_r, bus_error_flag_r, general_call_flag_r};
			end else if (reg_addr == isacr_pkg::OFS_CLOCK_CTRL) begin
				reg_rdata <= ccr_r;
			end else if (reg_addr == isacr_pkg::OFS_DATA) begin
				reg_rdata <= dr_r;
			end else if (reg_addr == isacr_pkg::OFS_OWN_LOW) begin
				reg_rdata <= oal_r;
			end else if (reg_addr == isacr_pkg::OFS_OWN_HIGH) begin
				reg_rdata <= {oah_r[7:6], 3'b000, oah_r[2:1], 1'b0};
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// byte engine, status flags and data register; clears come first so sets win, except busy, which a start seen mid-byte clears

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= isacr_pkg::ST_IDLE;
			ph_r <= 2'b00;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			hcnt_r <= 9'h000;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
			tx_r <= 1'b0;
			addr_ph_r <= 1'b0;
			dir_r <= 1'b0;
			ten_pend_r <= 1'b0;
			ack_seen_r <= 1'b0;
			slv_acked_r <= 1'b0;
			{sb_r, ten_bit_header_flag_r, btf_r, address_matched_flag_r, master_r, busy_r} <= 6'h00;
			{af_r, stop_seen_flag_r, arb_lost_flag_r, bus_error_flag_r, general_call_flag_r} <= 5'h00;
			{sr1_seen_r, sr2_seen_r, clr_start_r, clr_stop_r} <= 4'h0;
			dr_r <= isacr_pkg::RST_DATA;
		end else if (!pe || dis_wr) begin
			// disable releases the lines and clears every flag, data register kept;
			// the disabling write acts at its own edge so a read right after sees it
			state_r <= isacr_pkg::ST_IDLE;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
			ten_pend_r <= 1'b0;
			slv_acked_r <= 1'b0;
			{sb_r, ten_bit_header_flag_r, btf_r, address_matched_flag_r, master_r, busy_r} <= 6'h00;
			{af_r, stop_seen_flag_r, arb_lost_flag_r, bus_error_flag_r, general_call_flag_r} <= 5'h00;
			{sr1_seen_r, sr2_seen_r, clr_start_r, clr_stop_r} <= 4'h0;
			if (wr_dr) begin
				dr_r <= reg_wdata;
			end
		end else begin
			clr_start_r <= 1'b0;
			clr_stop_r <= 1'b0;
			hcnt_r <= tick ? 9'h000 : hcnt_r - 9'h001;
			// software clearing sequences
			if (rd_sr1) begin
				sr1_seen_r <= 1'b1;
				address_matched_flag_r <= 1'b0;
			end else if (rd_dr || wr_dr) begin
				sr1_seen_r <= 1'b0;
			end
			if (rd_sr2) begin
				sr2_seen_r <= 1'b1;
				{af_r, stop_seen_flag_r, arb_lost_flag_r, bus_error_flag_r} <= 4'h0;
			end else if (wr_dr) begin
				sr2_seen_r <= 1'b0;
			end
			if (wr_dr) begin
				dr_r <= reg_wdata;
			end
			// bus tracking from the lines themselves
			if (start_det) begin
				busy_r <= 1'b1;
			end
			if (stop_det) begin
				busy_r <= 1'b0;
				master_r <= 1'b0;
				general_call_flag_r <= 1'b0;
				slv_acked_r <= 1'b0;
				ten_pend_r <= 1'b0;
				if (ack_en && slv_acked_r && !master_r) begin
					stop_seen_flag_r <= 1'b1;
				end
			end

			case (state_r)
				isacr_pkg::ST_IDLE: begin
					scl_low_r <= 1'b0;
					sda_low_r <= 1'b0;
					if (ctrl_r[isacr_pkg::CTRL_START] && !busy_r) begin
						state_r <= isacr_pkg::ST_MSTART;
						ph_r <= 2'b00;
						hcnt_r <= half;
					end else if (start_det) begin
						state_r <= isacr_pkg::ST_SADDR;
						bit_r <= isacr_pkg::BIT_PRE;
						tx_r <= 1'b0;
					end
				end
				isacr_pkg::ST_MSTART: begin
					// release, wait high, pull data low, then pull clock low
					if (ph_r == 2'b00) begin
						sda_low_r <= 1'b0;
						if (tick) begin
							scl_low_r <= 1'b0;
							ph_r <= 2'b01;
							hcnt_r <= half;
						end
					end else if (ph_r == 2'b01) begin
						if (tick && scl_s2) begin
							sda_low_r <= 1'b1;
							ph_r <= 2'b10;
							hcnt_r <= half;
						end
					end else if (tick) begin
						scl_low_r <= 1'b1;
						sb_r <= 1'b1;
						master_r <= 1'b1;
						clr_start_r <= 1'b1;
						state_r <= isacr_pkg::ST_MHOLD;
					end
				end
				isacr_pkg::ST_MHOLD: begin
					scl_low_r <= 1'b1;
					if (sb_r) begin
						if (ctrl_r[isacr_pkg::CTRL_STOP]) begin
							sb_r <= 1'b0;
							state_r <= isacr_pkg::ST_MSTOP;
							ph_r <= 2'b00;
							hcnt_r <= half;
						end else if (wr_dr && sr1_seen_r) begin
							sb_r <= 1'b0;
							shift_r <= reg_wdata;
							sda_low_r <= ~reg_wdata[7];
							tx_r <= 1'b1;
							addr_ph_r <= 1'b1;
							bit_r <= 4'h0;
							hcnt_r <= half;
							state_r <= isacr_pkg::ST_MBYTE;
						end
					end else if (ten_bit_header_flag_r) begin
						if (wr_dr && sr2_seen_r) begin
							ten_bit_header_flag_r <= 1'b0;
							shift_r <= reg_wdata;
							sda_low_r <= ~reg_wdata[7];
							tx_r <= 1'b1;
							addr_ph_r <= 1'b0;
							bit_r <= 4'h0;
							hcnt_r <= half;
							state_r <= isacr_pkg::ST_MBYTE;
						end
					end else if (ctrl_r[isacr_pkg::CTRL_START]) begin
						btf_r <= 1'b0;
						state_r <= isacr_pkg::ST_MSTART;
						ph_r <= 2'b00;
						hcnt_r <= half;
					end else if (ctrl_r[isacr_pkg::CTRL_STOP]) begin
						btf_r <= 1'b0;
						state_r <= isacr_pkg::ST_MSTOP;
						ph_r <= 2'b00;
						hcnt_r <= half;
					end else if (sr1_seen_r && ((tx_r && wr_dr) || (!tx_r && rd_dr))) begin
						btf_r <= 1'b0;
						shift_r <= reg_wdata;
						sda_low_r <= tx_r & ~reg_wdata[7];
						addr_ph_r <= 1'b0;
						bit_r <= 4'h0;
						hcnt_r <= half;
						state_r <= isacr_pkg::ST_MBYTE;
					end
				end
				isacr_pkg::ST_MSTOP: begin
					// data low under low clock, release clock, then release data
					if (ph_r == 2'b00) begin
						sda_low_r <= 1'b1;
						if (tick) begin
							scl_low_r <= 1'b0;
							ph_r <= 2'b01;
							hcnt_r <= half;
						end
					end else if (tick && scl_s2) begin
						sda_low_r <= 1'b0;
						clr_stop_r <= 1'b1;
						state_r <= isacr_pkg::ST_IDLE;
					end
				end
				default: begin
					// master byte, slave address and slave byte share the bit engine
					if (state_r == isacr_pkg::ST_SHOLD) begin
						scl_low_r <= 1'b1;
					end else if (state_r == isacr_pkg::ST_MBYTE && tick) begin
						if (scl_low_r) begin
							scl_low_r <= 1'b0;
							hcnt_r <= half;
						end else if (scl_s2) begin
							scl_low_r <= 1'b1;
							hcnt_r <= half;
						end
					end
					if (state_r == isacr_pkg::ST_SHOLD) begin
						if (address_matched_flag_r) begin
							if (rd_sr1 && !dir_r) begin
								scl_low_r <= 1'b0;
								tx_r <= 1'b0;
								bit_r <= 4'h0;
								state_r <= isacr_pkg::ST_SBYTE;
							end
						end else if (dir_r && wr_dr && (!btf_r || sr1_seen_r)) begin
							btf_r <= 1'b0;
							shift_r <= reg_wdata;
							sda_low_r <= ~reg_wdata[7];
							tx_r <= 1'b1;
							scl_low_r <= 1'b0;
							bit_r <= 4'h0;
							state_r <= isacr_pkg::ST_SBYTE;
						end else if (!dir_r && btf_r && sr1_seen_r && rd_dr) begin
							btf_r <= 1'b0;
							scl_low_r <= 1'b0;
							bit_r <= 4'h0;
							state_r <= isacr_pkg::ST_SBYTE;
						end
					end else if (start_det || stop_det) begin
						if (mid_byte) begin
							bus_error_flag_r <= 1'b1;
							busy_r <= 1'b0;
						end
						sda_low_r <= 1'b0;
						scl_low_r <= 1'b0;
						master_r <= 1'b0;
						bit_r <= isacr_pkg::BIT_PRE;
						tx_r <= 1'b0;
						state_r <= start_det ? isacr_pkg::ST_SADDR : isacr_pkg::ST_IDLE;
					end else if (scl_rise) begin
						if (bit_r < isacr_pkg::BIT_ACK) begin
							shift_r <= {shift_r[6:0], sda_s2};
							if (master_r && tx_r && !sda_low_r && !sda_s2) begin
								arb_lost_flag_r <= 1'b1;
								master_r <= 1'b0;
								scl_low_r <= 1'b0;
								state_r <= isacr_pkg::ST_IDLE;
							end
						end else if (bit_r == isacr_pkg::BIT_ACK) begin
							ack_seen_r <= ~sda_s2;
						end
					end else if (scl_fall) begin
						if (bit_r == isacr_pkg::BIT_PRE) begin
							bit_r <= 4'h0;
						end else if (bit_r < isacr_pkg::BIT_ACK) begin
							bit_r <= bit_r + 4'h1;
							if (bit_r != 4'h7) begin
								sda_low_r <= tx_r & ~shift_r[7];
							end else if (tx_r) begin
								sda_low_r <= 1'b0;
							end else if (state_r == isacr_pkg::ST_SADDR) begin
								sda_low_r <= ack_en & addr_hit;
							end else begin
								sda_low_r <= ack_en;
							end
						end else begin
							// end of the acknowledge slot
							bit_r <= 4'h0;
							sda_low_r <= 1'b0;
							if (state_r == isacr_pkg::ST_SADDR) begin
								if (ack_en && hdr_hit) begin
									ten_pend_r <= 1'b1;
								end else if (ack_en && addr_hit) begin
									address_matched_flag_r <= 1'b1;
									general_call_flag_r <= gc_hit;
									dir_r <= shift_r[0] & ~a10_hit & ~gc_hit;
									slv_acked_r <= 1'b1;
									scl_low_r <= 1'b1;
									state_r <= isacr_pkg::ST_SHOLD;
								end else begin
									ten_pend_r <= 1'b0;
									state_r <= isacr_pkg::ST_IDLE;
								end
							end else if (!tx_r) begin
								dr_r <= shift_r;
								btf_r <= 1'b1;
								scl_low_r <= 1'b1;
								state_r <= (state_r == isacr_pkg::ST_MBYTE) ?
									isacr_pkg::ST_MHOLD : isacr_pkg::ST_SHOLD;
							end else if (!ack_seen_r) begin
								af_r <= 1'b1;
								if (state_r == isacr_pkg::ST_MBYTE) begin
									btf_r <= 1'b1;
									scl_low_r <= 1'b1;
									state_r <= isacr_pkg::ST_MHOLD;
								end else begin
									state_r <= isacr_pkg::ST_IDLE;
								end
							end else if (state_r == isacr_pkg::ST_SBYTE) begin
								btf_r <= 1'b1;
								scl_low_r <= 1'b1;
								state_r <= isacr_pkg::ST_SHOLD;
							end else if (addr_ph_r && shift_r[0]) begin
								tx_r <= 1'b0;
								addr_ph_r <= 1'b0;
							end else begin
								if (addr_ph_r && shift_r[7:3] == isacr_pkg::TEN_BIT_HEADER) begin
									ten_bit_header_flag_r <= 1'b1;
								end else begin
									btf_r <= 1'b1;
								end
								scl_low_r <= 1'b1;
								state_r <= isacr_pkg::ST_MHOLD;
							end
						end
					end
				end
			endcase
		end
	end

endmodule

/* File: include/isacr_pkg.sv */
// register map, field positions, reset values and timing constants of the two-wire block
package isacr_pkg;

	// register offsets on the plain register port
	localparam logic [2:0] OFS_CTRL       = 3'h0;
	localparam logic [2:0] OFS_STATUS_ONE = 3'h1;
	localparam logic [2:0] OFS_ERROR_STAT = 3'h2;
	localparam logic [2:0] OFS_CLOCK_CTRL = 3'h3;
	localparam logic [2:0] OFS_DATA       = 3'h4;
	localparam logic [2:0] OFS_OWN_LOW    = 3'h5;
	localparam logic [2:0] OFS_OWN_HIGH   = 3'h6;

	// control register fields
	localparam int CTRL_IRQ_EN    = 0;
	localparam int CTRL_STOP      = 1;
	localparam int CTRL_ACK_EN    = 2;
	localparam int CTRL_START     = 3;
	localparam int CTRL_GC_EN     = 4;
	localparam int CTRL_PERIPH_EN = 5;

	// clock control fields
	localparam int CCR_SPEED_MODE = 7;

	// own address high fields
	localparam int OAH_TIMING_LSB = 6;
	localparam int OAH_ADDR98_LSB = 1;

	// values after reset
	localparam logic [7:0] RST_CTRL       = 8'h00;
	localparam logic [7:0] RST_CLOCK_CTRL = 8'h00;
	localparam logic [7:0] RST_DATA       = 8'h00;
	localparam logic [7:0] RST_OWN_LOW    = 8'h00;
	localparam logic [7:0] RST_OWN_HIGH   = 8'h40;

	// address patterns
	localparam logic [7:0] ADDR_GENERAL_CALL = 8'h00;
	localparam logic [7:0] ADDR_NEVER_ANSWER = 8'h01;
	localparam logic [4:0] TEN_BIT_HEADER    = 5'h1e;

	// bit counter values: 8 is the acknowledge slot, 15 skips the fall of a start
	localparam logic [3:0] BIT_ACK  = 4'h8;
	localparam logic [3:0] BIT_PRE  = 4'hf;

	// scl half period in core clocks: the base keeps it above the input synchroniser lag
	localparam logic [8:0] SCL_HALF_BASE_FAST = 9'h004;
	localparam logic [8:0] SCL_HALF_BASE_STD  = 9'h008;

	// engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MSTART,
		ST_MHOLD,
		ST_MBYTE,
		ST_MSTOP,
		ST_SADDR,
		ST_SHOLD,
		ST_SBYTE
	} isacr_state_t;

endpackage

/* File: sim/isacr_bus_model.sv */
// pulled-up two-wire bus with a slave that may acknowledge each byte
`timescale 1ns/10ps
module isacr_bus_model (
	// clock, reset and behaviour
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ack_on,
	// design enables and resolved lines
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	output logic     scl_line,
	output logic     sda_line
);
	logic [3:0] fall_r;
	logic       ack_r, scl_d_r, sda_d_r;
	// pull-ups: a released line reads high, never the last driven value
	assign scl_line = scl_oe_n;
	assign sda_line = sda_oe_n & ~ack_r;
	// count scl falls from each start; the start's own fall is the first, so the
	// acknowledge slot follows the ninth fall and the next byte restarts at one
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fall_r <= 4'h0;
			ack_r <= 1'b0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_line;
			sda_d_r <= sda_line;
			ack_r <= ack_on && fall_r == 4'h9;
			if (scl_line && sda_d_r && !sda_line)
				fall_r <= 4'h0;
			else if (scl_d_r && !scl_line)
				fall_r <= (fall_r == 4'h9) ? 4'h1 : fall_r + 4'h1;
		end
	end
endmodule

/* File: sim/isacr_top_asserts.sv */
// port-level checks of the two-wire register block
`timescale 1ns/10ps
module isacr_top_asserts (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       arst_n,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// bus pins and event request
	input wire logic       scl_i,
	input wire logic       scl_o,
	input wire logic       scl_oe_n,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_n,
	input wire logic       irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic off_w, rd_err, rd_one, rd_oah, wr_ccr, rd_ccr;
	// decoded strobes; off_w is a control write with the enable bit low
	assign off_w = reg_wr && reg_addr == isacr_pkg::OFS_CTRL && !reg_wdata[5];
	assign rd_err = reg_rd && reg_addr == isacr_pkg::OFS_ERROR_STAT;
	assign rd_one = reg_rd && reg_addr == isacr_pkg::OFS_STATUS_ONE;
	assign rd_oah = reg_rd && reg_addr == isacr_pkg::OFS_OWN_HIGH;
	assign wr_ccr = reg_wr && reg_addr == isacr_pkg::OFS_CLOCK_CTRL;
	assign rd_ccr = reg_rd && reg_addr == isacr_pkg::OFS_CLOCK_CTRL;
	////////////////////////////////////////////////////////////////////////////////
	off_flags_a: assert property (
		off_w ##1 rd_err |=> reg_rdata == 8'h00) else $error("error flags kept");
	off_start_a: assert property (
		off_w ##1 rd_one |=> (reg_rdata & 8'h8f) == 8'h00) else $error("status kept");
	off_irq_a: assert property (off_w |=> !irq [*4]) else $error("irq after disable");
	off_free_a: assert property (
		off_w |-> ##[1:3] (scl_oe_n && sda_oe_n)) else $error("pins not released");
	clk_keep_a: assert property (
		wr_ccr ##1 rd_ccr |=> reg_rdata == $past(reg_wdata, 2)) else $error("clock ctrl lost");
	err_rsvd_a: assert property (rd_err |=> reg_rdata[7:5] == 3'h0) else $error("sr2 rsvd");
	oah_rsvd_a: assert property (
		rd_oah |=> reg_rdata[5:3] == 3'h0 && !reg_rdata[0]) else $error("own high rsvd");
	// a hold flag seen by software must coincide with scl pulled low
	hold_scl_a: assert property (
		rd_one ##1 (reg_rdata[0] || reg_rdata[3]) |-> !scl_oe_n) else $error("scl not held");
	drive_low_a: assert property (!scl_o && !sda_o) else $error("pin level not low");
endmodule

bind isacr_top isacr_top_asserts u_chk (.core_clk(core_clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));

/* File: sim/testbench.sv */
// self-checking bench for the two-wire register block
`timescale 1ns/10ps
module testbench;
	logic       core_clk, arst_n, reg_wr, reg_rd, irq, ack_on;
	logic       scl_line, sda_line, scl_o, sda_o, scl_oe_n, sda_oe_n;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, cap, d;
	int         err_count, cmp_count, i;
	////////////////////////////////////////////////////////////////////////////////
	isacr_top DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));
	isacr_bus_model u_bus (.core_clk(core_clk), .arst_n(arst_n), .ack_on(ack_on),
		.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_line(scl_line), .sda_line(sda_line));
	always #20 core_clk = ~core_clk;
	// one cycle; data is caught before the edge's updates land, so it is the last cycle's
	task bus(input logic w, r, input logic [2:0] a, input logic [7:0] v);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		cap = reg_rdata;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		bus(1'b1, 1'b0, a, v);
		bus(1'b0, 1'b0, a, v);
	endtask
	task rd(input logic [2:0] a, output logic [7:0] q);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		q = cap;
	endtask
	// write and read back to back, no idle cycle between
	task wrd(input logic [2:0] wa, input logic [7:0] wv, input logic [2:0] ra, output logic [7:0] q);
		bus(1'b1, 1'b0, wa, wv);
		rd(ra, q);
	endtask
	task chk(input string n, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task t_reset;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], d);
			chk("reset value", (a == 6) ? 8'h40 : 8'h00, d);
		end
		$display("t_reset done");
	endtask
	task t_regs;
		wr(isacr_pkg::OFS_OWN_HIGH, 8'hbf);
		rd(isacr_pkg::OFS_OWN_HIGH, d);
		chk("own high", 8'h86, d);
		wr(isacr_pkg::OFS_OWN_LOW, 8'ha5);
		wr(isacr_pkg::OFS_CTRL, 8'h20);
		wr(isacr_pkg::OFS_CTRL, 8'h20);
		wrd(isacr_pkg::OFS_OWN_HIGH, 8'h00, isacr_pkg::OFS_OWN_HIGH, d);
		chk("delay locked", 8'h80, d);
		wrd(isacr_pkg::OFS_CLOCK_CTRL, 8'hfe, isacr_pkg::OFS_CLOCK_CTRL, d);
		chk("clock ctrl", 8'hfe, d);
		wrd(isacr_pkg::OFS_CTRL, 8'h00, isacr_pkg::OFS_OWN_LOW, d);
		chk("own low kept", 8'ha5, d);
		rd(isacr_pkg::OFS_CLOCK_CTRL, d);
		chk("clock kept", 8'hfe, d);
		rd(3'h7, d);
		chk("unmapped", 8'h00, d);
		$display("t_regs done");
	endtask
	// shared master start and address byte, ending with scl held on byte done
	task mbyte(input logic ack);
		ack_on <= ack;
		wr(isacr_pkg::OFS_CLOCK_CTRL, 8'h85);
		wr(isacr_pkg::OFS_CTRL, 8'h20);
		wr(isacr_pkg::OFS_CTRL, 8'h2d);
		for (i = 0; i < 500 && irq !== 1'b1; i++) @(posedge core_clk);
		chk("start irq", 8'h01, {7'h00, irq});
		rd(isacr_pkg::OFS_STATUS_ONE, d);
		chk("start flags", 8'h83, d & 8'h83);
		wr(isacr_pkg::OFS_DATA, 8'ha6);
		d = 8'h00;
		for (i = 0; i < 400 && d[3] !== 1'b1; i++) rd(isacr_pkg::OFS_STATUS_ONE, d);
		chk("byte flags", 8'h88, d & 8'h89);
		chk("scl held", 8'h00, {7'h00, scl_oe_n});
	endtask
	task t_nack;
		mbyte(1'b0);
		rd(isacr_pkg::OFS_ERROR_STAT, d);
		chk("ack fail", 8'h10, d);
		rd(isacr_pkg::OFS_ERROR_STAT, d);
		chk("read clear", 8'h00, d);
		chk("still held", 8'h00, {7'h00, scl_oe_n});
		wr(isacr_pkg::OFS_CTRL, 8'h23);
		for (i = 0; i < 500 && (scl_oe_n & sda_oe_n) !== 1'b1; i++) @(posedge core_clk);
		chk("bus free", 8'h01, {7'h00, scl_oe_n & sda_oe_n});
		wrd(isacr_pkg::OFS_CTRL, 8'h00, isacr_pkg::OFS_ERROR_STAT, d);
		chk("stop flags", 8'h00, d);
		$display("t_nack done");
	endtask
	task t_ack;
		mbyte(1'b1);
		rd(isacr_pkg::OFS_ERROR_STAT, d);
		chk("no ack fail", 8'h00, d);
		wrd(isacr_pkg::OFS_CTRL, 8'h00, isacr_pkg::OFS_STATUS_ONE, d);
		chk("flags off", 8'h00, d & 8'h8f);
		chk("scl free", 8'h01, {7'h00, scl_oe_n});
		chk("irq off", 8'h00, {7'h00, irq});
		$display("t_ack done");
	endtask
	task test_done;
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		{reg_wr, reg_rd, ack_on} = 3'h0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		err_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset();
		t_regs();
		t_nack();
		t_ack();
		test_done();
	end
	// watchdog: the sequence needs under a thousand cycles, this allows 50000
	initial begin
		#2000000;
		err_count++;
		test_done();
	end
endmodule
